// ==== pim_irq_mask.v ====
/*
  Interrupt masking for the serial bus interface: six event flags set sticky
  status bits, the mask register gates them onto one interrupt output, and
  software reaches status, mask and raw flags over AXI4-Lite.
  Assumes the event flags come from logic on CLK_SYS and that the bus master
  keeps one write and one read in flight at most.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.vh"

module pim_irq_mask (
  input  wire                   CLK_SYS,
  input  wire                   SYS_RST,
  input  wire                   EVT_BUS_FREE,
  input  wire                   EVT_LOW_TMO,
  input  wire                   EVT_DATA_RDY,
  input  wire                   EVT_DATA_REQ,
  input  wire                   EVT_ADDR_RDY,
  input  wire                   EVT_MSG_END,
  input  wire [`PIM_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire                   S_AXI_AWVALID,
  output reg                    S_AXI_AWREADY,
  input  wire [31:0]            S_AXI_WDATA,
  input  wire [3:0]             S_AXI_WSTRB,
  input  wire                   S_AXI_WVALID,
  output reg                    S_AXI_WREADY,
  output reg  [1:0]             S_AXI_BRESP,
  output reg                    S_AXI_BVALID,
  input  wire                   S_AXI_BREADY,
  input  wire [`PIM_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire                   S_AXI_ARVALID,
  output reg                    S_AXI_ARREADY,
  output reg  [31:0]            S_AXI_RDATA,
  output reg  [1:0]             S_AXI_RRESP,
  output reg                    S_AXI_RVALID,
  input  wire                   S_AXI_RREADY,
  output reg                    IRQ
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  reg [`PIM_SRC_W-1:0]  flag_prev;
  reg [`PIM_SRC_W-1:0]  status;
  reg [`PIM_SRC_W-1:0]  bus_interrupt_mask;
  reg                   aw_full;
  reg                   w_full;
  reg [`PIM_ADDR_W-1:0] aw_addr;
  reg [31:0]            w_data;
  reg                   w_lane0;

  reg [`PIM_SRC_W-1:0]  next_status;
  reg [`PIM_SRC_W-1:0]  next_mask;
  reg                   next_aw_full;
  reg                   next_w_full;
  reg                   next_bvalid;
  reg                   next_rvalid;
  reg [1:0]             next_bresp;
  reg                   do_write;
  reg                   next_irq;
  reg                   aw_take;
  reg                   w_take;
  reg                   ar_take;
  reg                   b_done;
  reg                   r_done;

  // -------------------------------------------------------------------------
  // Event edges
  // -------------------------------------------------------------------------
  // The previous flags reset low, so a flag that idles low gives no false edge.
  wire [`PIM_SRC_W-1:0] flag_now;
  wire [`PIM_SRC_W-1:0] flag_rise;

  assign flag_now = {EVT_MSG_END, EVT_ADDR_RDY, EVT_DATA_REQ,
                     EVT_DATA_RDY, EVT_LOW_TMO, EVT_BUS_FREE};
  // A flag counts once, on its assertion, so a long level is one event.
  assign flag_rise = flag_now & ~flag_prev;

  // -------------------------------------------------------------------------
  // Decoding
  // -------------------------------------------------------------------------
  function addr_is;
    input [`PIM_ADDR_W-1:0] addr;
    input [`PIM_ADDR_W-1:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  function is_mapped;
    input [`PIM_ADDR_W-1:0] addr;
    begin
      is_mapped = addr_is(addr, `PIM_OFS_STATUS) || addr_is(addr, `PIM_OFS_MASK) ||
                  addr_is(addr, `PIM_OFS_RAW);
    end
  endfunction

  function [1:0] resp_for;
    input [`PIM_ADDR_W-1:0] addr;
    begin
      resp_for = is_mapped(addr) ? `PIM_RESP_OKAY : `PIM_RESP_SLVERR;
    end
  endfunction

  // Unused upper bits read as zero, so software may compare whole words.
  function [31:0] pad_field;
    input [`PIM_SRC_W-1:0] field;
    begin
      pad_field = {{(32-`PIM_SRC_W){1'b0}}, field};
    end
  endfunction

  function [31:0] read_word;
    input [`PIM_ADDR_W-1:0] addr;
    begin
      case (addr)
        `PIM_OFS_STATUS: read_word = pad_field(status);
        `PIM_OFS_MASK:   read_word = pad_field(bus_interrupt_mask);
        `PIM_OFS_RAW:    read_word = pad_field(flag_now);
        default:         read_word = `PIM_WORD_ZERO;
      endcase
    end
  endfunction

  // -------------------------------------------------------------------------
  // Next values
  // -------------------------------------------------------------------------
  always @* begin
    aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
    w_take   = S_AXI_WVALID && S_AXI_WREADY;
    ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;
    b_done   = S_AXI_BVALID && S_AXI_BREADY;
    r_done   = S_AXI_RVALID && S_AXI_RREADY;
    // A new write waits until the previous response has been taken.
    do_write = aw_full && w_full && !S_AXI_BVALID;
  end

  always @* begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_bvalid  = S_AXI_BVALID;
    next_bresp   = S_AXI_BRESP;
    if (aw_take) begin
      next_aw_full = 1'b1;
    end
    if (w_take) begin
      next_w_full = 1'b1;
    end
    if (b_done) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = resp_for(aw_addr);
    end
  end

  // -------------------------------------------------------------------------
  // Register next values
  // -------------------------------------------------------------------------
  // Only byte lane 0 carries status and mask bits; other lanes are ignored.
  always @* begin
    next_status = status;
    next_mask   = bus_interrupt_mask;
    if (do_write && w_lane0 && addr_is(aw_addr, `PIM_OFS_STATUS)) begin
      next_status = status & ~w_data[`PIM_SRC_W-1:0];
    end
    if (do_write && w_lane0 && addr_is(aw_addr, `PIM_OFS_MASK)) begin
      next_mask = w_data[`PIM_SRC_W-1:0];
    end
    // Setting after the clear lets an event in the clearing cycle survive.
    next_status = next_status | flag_rise;
  end

  // -------------------------------------------------------------------------
  // Read channel next value
  // -------------------------------------------------------------------------
  always @* begin
    next_rvalid = S_AXI_RVALID;
    if (ar_take) begin
      next_rvalid = 1'b1;
    end else if (r_done) begin
      next_rvalid = 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt next value
  // -------------------------------------------------------------------------
  // Unmasked sources combined.
  always @* begin
    next_irq = |(status & ~bus_interrupt_mask);
  end

  // -------------------------------------------------------------------------
  // Event and register state
  // -------------------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_prev          <= `PIM_STATUS_RST;
      status             <= `PIM_STATUS_RST;
      bus_interrupt_mask <= `PIM_MASK_RST;
    end else begin
      flag_prev          <= flag_now;
      status             <= next_status;
      bus_interrupt_mask <= next_mask;
    end
  end

  // -------------------------------------------------------------------------
  // Write channel
  // -------------------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PIM_RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      // Ready stays low while a half is held or a response waits.
      S_AXI_AWREADY <= !next_aw_full && !next_bvalid;
      S_AXI_WREADY  <= !next_w_full && !next_bvalid;
      S_AXI_BVALID  <= next_bvalid;
      S_AXI_BRESP   <= next_bresp;
    end
  end

  // -------------------------------------------------------------------------
  // Write capture
  // -------------------------------------------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_addr <= `PIM_ADDR_RST;
      w_data  <= `PIM_WORD_ZERO;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data  <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Read channel
  // -------------------------------------------------------------------------
  // Read data is captured once at the address handshake, so it stands until taken.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= `PIM_WORD_ZERO;
      S_AXI_RRESP   <= `PIM_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !next_rvalid;
      S_AXI_RVALID  <= next_rvalid;
      if (ar_take) begin
        S_AXI_RDATA <= read_word(S_AXI_ARADDR);
        S_AXI_RRESP <= resp_for(S_AXI_ARADDR);
      end
    end
  end

  // -------------------------------------------------------------------------
  // Interrupt output
  // -------------------------------------------------------------------------
  // Gate and combine sources.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= next_irq;
    end
  end

endmodule // pim_irq_mask

`default_nettype wire

// ==== pim_regs.vh ====
/*
  Register map, field positions and reset values of the bus interrupt mask block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PIM_REGS_VH
`define PIM_REGS_VH

// ---------------------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------------------
`define PIM_ADDR_W          8
`define PIM_OFS_STATUS      8'h00
`define PIM_OFS_MASK        8'h04
`define PIM_OFS_RAW         8'h08

// ---------------------------------------------------------------------------
// Fields
// ---------------------------------------------------------------------------
`define PIM_SRC_W           6
`define PIM_BIT_BUS_FREE    0
`define PIM_BIT_LOW_TMO     1
`define PIM_BIT_DATA_RDY    2
`define PIM_BIT_DATA_REQ    3
`define PIM_BIT_ADDR_RDY    4
`define PIM_BIT_MSG_END     5

// ---------------------------------------------------------------------------
// Reset values and responses
// ---------------------------------------------------------------------------
`define PIM_MASK_RST        6'h3F
`define PIM_STATUS_RST      6'h00
`define PIM_RESP_OKAY       2'h0
`define PIM_RESP_SLVERR     2'h2
`define PIM_ADDR_RST        8'h00
`define PIM_WORD_ZERO       32'h00000000

`endif

// ==== pim_irq_mask_asserts.sv ====
/* Checker for pim_irq_mask: shadows the mask from bus writes, ties IRQ to events.
   Assumes it is bound to pim_irq_mask and that WSTRB[0] qualifies a write. */
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.vh"
module pim_irq_mask_asserts (
  input wire logic                   CLK_SYS,
  input wire logic                   SYS_RST,
  input wire logic                   EVT_BUS_FREE,
  input wire logic                   EVT_LOW_TMO,
  input wire logic                   EVT_DATA_RDY,
  input wire logic                   EVT_DATA_REQ,
  input wire logic                   EVT_ADDR_RDY,
  input wire logic                   EVT_MSG_END,
  input wire logic [`PIM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic                   S_AXI_AWVALID,
  input wire logic                   S_AXI_AWREADY,
  input wire logic [31:0]            S_AXI_WDATA,
  input wire logic [3:0]             S_AXI_WSTRB,
  input wire logic                   S_AXI_WVALID,
  input wire logic                   S_AXI_WREADY,
  input wire logic                   S_AXI_BVALID,
  input wire logic                   S_AXI_BREADY,
  input wire logic                   IRQ
);
  reg [`PIM_ADDR_W-1:0] wa;
  reg [5:0]             wd;
  reg [5:0]             mk;
  reg                   ws;
  reg                   ga;
  reg                   gw;
  // ----
  // Mask shadow, updated on the edge the block applies the write.
  // ----
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mk <= `PIM_MASK_RST;
      ga <= 1'b0;
      gw <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) wa <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd <= S_AXI_WDATA[5:0];
      if (S_AXI_WVALID && S_AXI_WREADY) ws <= S_AXI_WSTRB[0];
      ga <= (ga | (S_AXI_AWVALID & S_AXI_AWREADY)) & ~(S_AXI_BVALID & S_AXI_BREADY);
      gw <= (gw | (S_AXI_WVALID & S_AXI_WREADY)) & ~(S_AXI_BVALID & S_AXI_BREADY);
      if (ga && gw && !S_AXI_BVALID && wa == `PIM_OFS_MASK && ws) mk <= wd;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_addr_rdy_gate: assert property ($rose(EVT_ADDR_RDY) && !mk[4] |-> ##2 IRQ)
    else $error("No IRQ after address ready.");
  a_data_req_gate: assert property ($rose(EVT_DATA_REQ) && !mk[3] |-> ##2 IRQ)
    else $error("No IRQ after data request.");
  a_data_rdy_gate: assert property ($rose(EVT_DATA_RDY) && !mk[2] |-> ##2 IRQ)
    else $error("No IRQ after data ready.");
  a_low_tmo_gate: assert property ($rose(EVT_LOW_TMO) && !mk[1] |-> ##2 IRQ)
    else $error("No IRQ after clock low timeout.");
  a_bus_free_gate: assert property ($rose(EVT_BUS_FREE) && !mk[0] |-> ##2 IRQ)
    else $error("No IRQ after bus free.");
  a_msg_end_gate: assert property ($rose(EVT_MSG_END) && !mk[5] |-> ##2 IRQ)
    else $error("No IRQ after end of message.");
  a_all_masked_quiet: assert property ($past(&mk) |-> !IRQ)
    else $error("IRQ high while every source is masked.");
  a_irq_sticky: assert property ($fell(IRQ) |-> $past(S_AXI_BVALID))
    else $error("IRQ fell without a register write.");
endmodule // pim_irq_mask_asserts
bind pim_irq_mask pim_irq_mask_asserts pim_irq_mask_asserts_inst (.*);
`default_nettype wire

// ==== pim_irq_mask_tb.sv ====
/* Self-checking bench for pim_irq_mask over AXI4-Lite.
   Assumes the register map of pim_regs.vh; WSTRB is held at all ones. */
`timescale 1ns/1ps
`default_nettype none
`include "pim_regs.vh"
module pim_irq_mask_tb;
  reg clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  reg [5:0]  ev = 6'h00;
  reg [7:0]  awa = 8'h00, ara = 8'h00;
  reg [31:0] wd = 32'h00000000, rdat;
  reg [1:0]  resp;
  reg [12:0] rows [0:11];
  wire awr, wr_rdy, bv, arr, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rd_data;
  integer err_count = 0, check_count = 0, cyc = 0, i;
  always #10 clk = ~clk;
  pim_irq_mask pim_irq_mask_inst (.CLK_SYS(clk), .SYS_RST(rst), .EVT_BUS_FREE(ev[0]),
    .EVT_LOW_TMO(ev[1]), .EVT_DATA_RDY(ev[2]), .EVT_DATA_REQ(ev[3]), .EVT_ADDR_RDY(ev[4]),
    .EVT_MSG_END(ev[5]), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_data), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .IRQ(irq));
  // ----
  // Tasks
  // ----
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d.", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
      do begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wr_rdy) wv <= 1'b0;
      end while (!bv);
      bre <= 1'b0;
      resp = br;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      {ara, arv, rre} <= {a, 2'h3};
      do begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end while (!rv);
      rre <= 1'b0;
      rdat = rd_data;
      resp = rr;
    end
  endtask
  // The bench should need well under 1000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    for (i = 0; i < 12; i = i + 1)
      rows[i] = {i < 6, 6'h01 << (i % 6), (i < 6) ? ~(6'h01 << (i % 6)) : 6'h3F};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PIM_OFS_MASK);
    chk("mask reset", rdat, `PIM_MASK_RST);
    for (i = 0; i < 12; i = i + 1) begin
      wr(`PIM_OFS_MASK, rows[i][5:0]);
      chk("mask resp", resp, `PIM_RESP_OKAY);
      @(posedge clk);
      ev <= rows[i][11:6];
      @(posedge clk);
      ev <= 6'h00;
      repeat (3) @(posedge clk);
      chk("irq", irq, rows[i][12]);
      rd(`PIM_OFS_STATUS);
      chk("status", rdat, rows[i][11:6]);
      wr(`PIM_OFS_STATUS, 32'h3F);
      repeat (3) @(posedge clk);
      chk("irq clear", irq, 0);
      $display("Row %0d done.", i);
    end
    ev <= 6'h2A;
    rd(`PIM_OFS_RAW);
    ev <= 6'h00;
    chk("raw flags", rdat, 32'h2A);
    wr(`PIM_OFS_STATUS, 32'h3F);
    ev <= 6'h02;
    @(posedge clk);
    ev <= 6'h00;
    fork
      wr(`PIM_OFS_STATUS, 32'h3F);
      begin
        repeat (2) @(posedge clk);
        ev <= 6'h01;
        @(posedge clk);
        ev <= 6'h00;
      end
    join
    rd(`PIM_OFS_STATUS);
    chk("set wins", rdat, 32'h01);
    wr(`PIM_OFS_STATUS, 32'h3F);
    $display("Raw flags and set-wins done.");
    wr(8'h10, 32'h0);
    chk("unmapped resp", resp, `PIM_RESP_SLVERR);
    rd(8'h10);
    chk("unmapped read", rdat, 0);
    chk("unmapped rresp", resp, `PIM_RESP_SLVERR);
    wr(`PIM_OFS_MASK, 32'h0);
    rd(`PIM_OFS_MASK);
    chk("mask written", rdat, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PIM_OFS_MASK);
    chk("mask rereset", rdat, `PIM_MASK_RST);
    $display("Unmapped and second reset done.");
    finish_test;
  end
endmodule // pim_irq_mask_tb
`default_nettype wire
